// ===== hw/dpp_defines.vh
// constants shared by the playback path files
`ifndef DPP_DEFINES_VH
`define DPP_DEFINES_VH
// register byte offsets
`define DPP_A_CTRL 8'h00
`define DPP_A_VOL 8'h04
`define DPP_A_MIX 8'h08
`define DPP_A_DRC1 8'h0C
`define DPP_A_DRC2 8'h10
`define DPP_A_DRC3 8'h14
`define DPP_A_ATT 8'h18
`define DPP_A_STAT 8'h1C
// reset values
`define DPP_CTRL_RST 10'h000
`define DPP_VOL_RST 16'hCECE
`define DPP_MIX_RST 8'h21
`define DPP_DRC1_RST 17'h00000
`define DPP_DRC2_RST 30'h0000016F
`define DPP_DRC3_RST 6'h00
`define DPP_ATT_RST 12'h000
// control bit positions
`define DPP_C_INV 0
`define DPP_C_OSR 1
`define DPP_C_SMUTE 3
`define DPP_C_MUTEL 4
`define DPP_C_MUTER 5
`define DPP_C_SMOOTH 6
`define DPP_C_CRX 7
`define DPP_C_CTX 8
`define DPP_C_ALAW 9
// volume and gain arithmetic
`define DPP_VOL_0DB 9'h0CE
`define DPP_CUR_RST 8'hCE
`define DPP_HDB_BIAS 10'h108
`define DPP_STEPS_OCT 10'h00C
`define DPP_GAIN_SH0 6'h25
`define DPP_HDB_MIN 16'hFF01
`define DPP_HDB_MAX 16'h0030
// level estimate in eighths of a dB, knee offsets in dB, compressor time and slope codes
`define DPP_FULL_BIT 16'h0017
`define DPP_Q3_PER_BIT 16'h0030
`define DPP_Q3_PER_FRAC 16'h0006
`define DPP_FLOOR_DB 16'hFB90
`define DPP_EXP_KNEE0 16'h0012
`define DPP_GATE_KNEE0 16'h0023
`define DPP_PK_DCY0 5'h06
`define DPP_CMP_ATK_MAX 5'h0C
`define DPP_CMP_DCY_MAX 5'h10
`define DPP_PK_ATK_MAX 5'h07
`define DPP_LMT_ONE 3'h7
`define DPP_CMP_ONE 3'h5
// auto attenuate timing in samples, and attenuation ceiling in steps
`define DPP_ZERO_RUN 11'h400
`define DPP_DOWN_STEP 8'h80
`define DPP_ATT_MAX 6'h36
// companding
`define DPP_MU_CLIP 14'h1FDE
`define DPP_MU_BIAS 14'h0021
`define DPP_A_SEG0 12'h020
`define DPP_A_XOR 8'h55
`endif

// ===== hw/dpp_gain.v
// half-dB step gain stage with saturation
`timescale 1ns/1ps
`default_nettype none
`include "dpp_defines.vh"
module dpp_gain (
    input wire signed [23:0] din,
    input wire signed [8:0] hdb,
    output wire [23:0] dout
);
    // bias keeps the octave split on unsigned values only
    wire [9:0] nn = {hdb[8], hdb} + `DPP_HDB_BIAS;
    wire [9:0] oct = nn / `DPP_STEPS_OCT;
    wire [9:0] frac = nn % `DPP_STEPS_OCT;
    reg [16:0] mant;
    always @* begin
        case (frac[3:0])
            4'h0: mant = 17'h08000;
            4'h1: mant = 17'h0879C;
            4'h2: mant = 17'h08FAD;
            4'h3: mant = 17'h09837;
            4'h4: mant = 17'h0A145;
            4'h5: mant = 17'h0AADC;
            4'h6: mant = 17'h0B505;
            4'h7: mant = 17'h0BFC9;
            4'h8: mant = 17'h0CB30;
            4'h9: mant = 17'h0D745;
            4'hA: mant = 17'h0E412;
            default: mant = 17'h0F1A2;
        endcase
    end
    wire signed [41:0] prod = din * $signed({1'b0, mant});
    wire [5:0] sh = `DPP_GAIN_SH0 - oct[5:0];
    wire signed [41:0] sc = prod >>> sh;
    wire fits = (&sc[41:23]) | ~(|sc[41:23]);
    assign dout = fits ? sc[23:0] : {sc[41], {23{~sc[41]}}};
endmodule
`default_nettype wire

// ===== hw/dpp_top.v
// playback digital path: volume, mixer, compressor, attenuate, companding
`timescale 1ns/1ps
`default_nettype none
`include "dpp_defines.vh"
module dpp_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire smp_valid,
    input wire [15:0] sp_l,
    input wire [15:0] sp_r,
    input wire [23:0] adc_l,
    input wire [23:0] adc_r,
    output wire out_valid,
    output wire [23:0] out_l,
    output wire [23:0] out_r,
    output wire [1:0] osr_sel,
    output wire [7:0] pb_code_l,
    output wire [7:0] pb_code_r,
    output wire [7:0] cap_code_l,
    output wire [7:0] cap_code_r,
    output wire [5:0] hp_atten
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DOWN = 3'b010;
    localparam ST_UP = 3'b100;

    reg [9:0] ctrl_r;
    reg [15:0] vol_r;
    reg [7:0] mix_r;
    reg [16:0] drc1_r;
    reg [29:0] drc2_r;
    reg [5:0] drc3_r;
    reg [11:0] att_r;
    reg [31:0] prdata_r;
    reg pslverr_r;

    function [23:0] sat24;
        input [27:0] v;
        begin
            if ((&v[27:23]) | ~(|v[27:23]))
                sat24 = v[23:0];
            else
                sat24 = {v[27], {23{~v[27]}}};
        end
    endfunction

    // compressor slope: code 0 flat, one_code and above unity, else 1/2^code
    function signed [15:0] cslope;
        input signed [15:0] d;
        input [2:0] code;
        input [2:0] one_code;
        begin
            if (code == 3'h0)
                cslope = 16'h0000;
            else if (code >= one_code)
                cslope = d;
            else
                cslope = d >>> code;
        end
    endfunction

    // peak magnitude to level in eighths of a dB, 6dB per bit
    function signed [15:0] lvl_db;
        input [23:0] m;
        integer i;
        reg [4:0] p;
        reg hit;
        reg [23:0] t;
        begin
            p = 5'h00;
            hit = 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                if (!hit && m[i]) begin
                    p = i[4:0];
                    hit = 1'b1;
                end
            end
            t = (p >= 5'h03) ? (m >> (p - 5'h03)) : 24'h000000;
            if (!hit)
                lvl_db = `DPP_FLOOR_DB;
            else
                lvl_db = ({11'h000, p} - `DPP_FULL_BIT) * `DPP_Q3_PER_BIT
                         + {13'h0000, t[2:0]} * `DPP_Q3_PER_FRAC;
        end
    endfunction

    // G.711 compression of the top bits of a 24-bit sample
    function [7:0] compand;
        input [23:0] s;
        input alaw;
        integer i;
        reg [13:0] mag;
        reg [2:0] e;
        reg [13:0] t;
        begin
            e = 3'h0;
            if (alaw) begin
                mag = s[23] ? {1'b0, ~s[23:11]} : {1'b0, s[23:11]};
                for (i = 5; i <= 11; i = i + 1)
                    if (mag[i])
                        e = i[2:0] - 3'h4;
                t = (e == 3'h0) ? (mag >> 1) : (mag >> e);
                compand = {~s[23], e, t[3:0]} ^ `DPP_A_XOR;
            end else begin
                mag = s[23] ? (~s[23:10] + 14'h0001) : s[23:10];
                if (mag > `DPP_MU_CLIP)
                    mag = `DPP_MU_CLIP;
                mag = mag + `DPP_MU_BIAS;
                for (i = 5; i <= 12; i = i + 1)
                    if (mag[i])
                        e = i[2:0] - 3'h5;
                // widened so the top segment still shifts by eight
                t = mag >> ({1'b0, e} + 4'h1);
                compand = ~{s[23], e, t[3:0]};
            end
        end
    endfunction

    // register bus: zero wait states, read data captured in setup phase
    wire wr_en = psel & penable & pwrite;
    reg [31:0] rd_mux;
    reg rd_err;
    reg [2:0] st_r;
    reg [5:0] hpa_r;
    reg [7:0] cur_l_r;
    reg [7:0] cur_r_r;
    always @* begin
        rd_err = 1'b0;
        if (paddr == `DPP_A_CTRL)
            rd_mux = {22'h000000, ctrl_r};
        else if (paddr == `DPP_A_VOL)
            rd_mux = {16'h0000, vol_r};
        else if (paddr == `DPP_A_MIX)
            rd_mux = {24'h000000, mix_r};
        else if (paddr == `DPP_A_DRC1)
            rd_mux = {15'h0000, drc1_r};
        else if (paddr == `DPP_A_DRC2)
            rd_mux = {2'h0, drc2_r};
        else if (paddr == `DPP_A_DRC3)
            rd_mux = {26'h0000000, drc3_r};
        else if (paddr == `DPP_A_ATT)
            rd_mux = {20'h00000, att_r};
        else if (paddr == `DPP_A_STAT)
            rd_mux = {7'h00, cur_r_r, cur_l_r, st_r, hpa_r};
        else begin
            rd_mux = 32'h00000000;
            rd_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DPP_CTRL_RST;
            vol_r <= `DPP_VOL_RST;
            mix_r <= `DPP_MIX_RST;
            drc1_r <= `DPP_DRC1_RST;
            drc2_r <= `DPP_DRC2_RST;
            drc3_r <= `DPP_DRC3_RST;
            att_r <= `DPP_ATT_RST;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            if (psel & ~penable) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_r <= rd_err;
            end
            if (wr_en && paddr == `DPP_A_CTRL)
                ctrl_r <= pwdata[9:0];
            if (wr_en && paddr == `DPP_A_VOL)
                vol_r <= pwdata[15:0];
            if (wr_en && paddr == `DPP_A_MIX)
                mix_r <= pwdata[7:0];
            if (wr_en && paddr == `DPP_A_DRC1)
                drc1_r <= pwdata[16:0];
            if (wr_en && paddr == `DPP_A_DRC2)
                drc2_r <= pwdata[29:0];
            if (wr_en && paddr == `DPP_A_DRC3)
                drc3_r <= pwdata[5:0];
            if (wr_en && paddr == `DPP_A_ATT)
                att_r <= pwdata[11:0];
        end
    end
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;
    assign osr_sel = ctrl_r[`DPP_C_OSR+1:`DPP_C_OSR];

    // stage 1: volume on the serial input, widened to 24 bits
    wire [23:0] in_l = {sp_l, 8'h00};
    wire [23:0] in_r = {sp_r, 8'h00};
    wire [23:0] vg_l;
    wire [23:0] vg_r;
    dpp_gain u_vol_l (
        .din(in_l),
        .hdb({1'b0, cur_l_r} - `DPP_VOL_0DB),
        .dout(vg_l)
    );
    dpp_gain u_vol_r (
        .din(in_r),
        .hdb({1'b0, cur_r_r} - `DPP_VOL_0DB),
        .dout(vg_r)
    );
    reg [23:0] v_l_r, v_r_r, a_l_r, a_r_r;
    reg v1_r;
    wire [7:0] tgt_l = ctrl_r[`DPP_C_SMUTE] ? 8'h00 : vol_r[7:0];
    wire [7:0] tgt_r = ctrl_r[`DPP_C_SMUTE] ? 8'h00 : vol_r[15:8];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v_l_r <= 24'h000000;
            v_r_r <= 24'h000000;
            a_l_r <= 24'h000000;
            a_r_r <= 24'h000000;
            v1_r <= 1'b0;
            cur_l_r <= `DPP_CUR_RST;
            cur_r_r <= `DPP_CUR_RST;
        end else begin
            v1_r <= smp_valid;
            if (smp_valid) begin
                // mute is immediate; code zero reads as silence
                v_l_r <= (ctrl_r[`DPP_C_MUTEL] || cur_l_r == 8'h00) ? 24'h000000 : vg_l;
                v_r_r <= (ctrl_r[`DPP_C_MUTER] || cur_r_r == 8'h00) ? 24'h000000 : vg_r;
                a_l_r <= adc_l;
                a_r_r <= adc_r;
                // one half-dB step per sample avoids zipper clicks
                if (cur_l_r < tgt_l)
                    cur_l_r <= cur_l_r + 8'h01;
                else if (cur_l_r > tgt_l)
                    cur_l_r <= cur_l_r - 8'h01;
                if (cur_r_r < tgt_r)
                    cur_r_r <= cur_r_r + 8'h01;
                else if (cur_r_r > tgt_r)
                    cur_r_r <= cur_r_r - 8'h01;
            end
        end
    end

    // stage 2: mixer, each output sums its enabled sources
    wire [27:0] mx_sl = {{4{v_l_r[23]}}, v_l_r};
    wire [27:0] mx_sr = {{4{v_r_r[23]}}, v_r_r};
    wire [27:0] mx_al = {{4{a_l_r[23]}}, a_l_r};
    wire [27:0] mx_ar = {{4{a_r_r[23]}}, a_r_r};
    wire [27:0] sum_l = (mix_r[0] ? mx_sl : 28'h0) + (mix_r[1] ? mx_sr : 28'h0)
                      + (mix_r[2] ? mx_al : 28'h0) + (mix_r[3] ? mx_ar : 28'h0);
    wire [27:0] sum_r = (mix_r[4] ? mx_sl : 28'h0) + (mix_r[5] ? mx_sr : 28'h0)
                      + (mix_r[6] ? mx_al : 28'h0) + (mix_r[7] ? mx_ar : 28'h0);
    wire [23:0] mx_l = sat24(sum_l);
    wire [23:0] mx_r = sat24(sum_r);

    // compressor: linked stereo peak, static curve, smoothed gain
    wire [23:0] abs_l = mx_l[23] ? (~mx_l + 24'h000001) : mx_l;
    wire [23:0] abs_r = mx_r[23] ? (~mx_r + 24'h000001) : mx_r;
    wire [23:0] pk_in = (abs_l > abs_r) ? abs_l : abs_r;
    reg [23:0] peak_r;
    reg signed [31:0] gacc_r;
    reg signed [15:0] tprev_r;
    wire [4:0] pk_atk = (drc1_r[3:0] > `DPP_PK_ATK_MAX) ? `DPP_PK_ATK_MAX : {1'b0, drc1_r[3:0]};
    wire [4:0] pk_dcy = (drc1_r[7:4] > `DPP_PK_ATK_MAX) ? `DPP_PK_ATK_MAX : {1'b0, drc1_r[7:4]};
    wire [4:0] g_atk = (drc1_r[11:8] > `DPP_CMP_ATK_MAX) ? `DPP_CMP_ATK_MAX : {1'b0, drc1_r[11:8]};
    wire [4:0] g_dcy = (drc1_r[15:12] + `DPP_PK_DCY0 > `DPP_CMP_DCY_MAX) ? `DPP_CMP_DCY_MAX
                       : {1'b0, drc1_r[15:12]} + `DPP_PK_DCY0;
    reg signed [15:0] x, k1, k2, k3, k4, y1, y2, y3, y4, y, t, ts, hd;
    reg signed [31:0] gdiff;
    always @* begin
        x = lvl_db(peak_r);
        k1 = -({11'h000, drc2_r[17:13]} <<< 3);
        k2 = -({10'h000, drc2_r[23:18]} <<< 3);
        k3 = -(({10'h000, drc2_r[29:24]} + `DPP_EXP_KNEE0) <<< 3);
        k4 = -(({10'h000, drc3_r} + `DPP_GATE_KNEE0) <<< 3);
        y1 = k1;
        y2 = y1 + cslope(k2 - k1, drc2_r[5:3], `DPP_CMP_ONE);
        y3 = y2 + cslope(k3 - k2, drc2_r[8:6], `DPP_CMP_ONE);
        y4 = y3 + ((k4 - k3) <<< drc2_r[10:9]);
        if (x >= k1)
            y = y1 + cslope(x - k1, drc2_r[2:0], `DPP_LMT_ONE);
        else if (x >= k2)
            y = y1 + cslope(x - k1, drc2_r[5:3], `DPP_CMP_ONE);
        else if (x >= k3)
            y = y2 + cslope(x - k2, drc2_r[8:6], `DPP_CMP_ONE);
        else if (x >= k4)
            y = y3 + ((x - k3) <<< drc2_r[10:9]);
        else
            y = y4 + ((x - k4) <<< drc2_r[12:11]);
        t = y - x;
        // averaging with last target rounds off the corners at knees
        ts = ctrl_r[`DPP_C_SMOOTH] ? ((t + tprev_r) >>> 1) : t;
        gdiff = {ts, 16'h0000} - gacc_r;
        hd = $signed(gacc_r[31:16]) >>> 2;
        if (!drc1_r[16])
            hd = 16'h0000;
        else if (hd < $signed(`DPP_HDB_MIN))
            hd = `DPP_HDB_MIN;
        else if (hd > $signed(`DPP_HDB_MAX))
            hd = `DPP_HDB_MAX;
    end
    wire [23:0] dg_l, dg_r;
    dpp_gain u_drc_l (
        .din(mx_l),
        .hdb(hd[8:0]),
        .dout(dg_l)
    );
    dpp_gain u_drc_r (
        .din(mx_r),
        .hdb(hd[8:0]),
        .dout(dg_r)
    );
    wire [23:0] fin_l = ctrl_r[`DPP_C_INV] ? sat24(28'h0 - {{4{dg_l[23]}}, dg_l}) : dg_l;
    wire [23:0] fin_r = ctrl_r[`DPP_C_INV] ? sat24(28'h0 - {{4{dg_r[23]}}, dg_r}) : dg_r;

    reg [23:0] out_l_r, out_r_r;
    reg out_valid_r;
    reg [7:0] pbc_l_r, pbc_r_r, cpc_l_r, cpc_r_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peak_r <= 24'h000000;
            gacc_r <= 32'h00000000;
            tprev_r <= 16'h0000;
            out_l_r <= 24'h000000;
            out_r_r <= 24'h000000;
            out_valid_r <= 1'b0;
            pbc_l_r <= 8'h00;
            pbc_r_r <= 8'h00;
            cpc_l_r <= 8'h00;
            cpc_r_r <= 8'h00;
        end else begin
            out_valid_r <= v1_r;
            if (v1_r) begin
                if (pk_in > peak_r)
                    peak_r <= peak_r + ((pk_in - peak_r) >> pk_atk);
                else
                    peak_r <= peak_r - ((peak_r - pk_in) >> (pk_dcy + `DPP_PK_DCY0));
                if (gdiff < 0)
                    gacc_r <= gacc_r + (gdiff >>> g_atk);
                else
                    gacc_r <= gacc_r + (gdiff >>> g_dcy);
                tprev_r <= t;
                out_l_r <= fin_l;
                out_r_r <= fin_r;
                // word length of 8 bits is the host's duty here
                pbc_l_r <= ctrl_r[`DPP_C_CRX] ? compand(fin_l, ctrl_r[`DPP_C_ALAW]) : 8'h00;
                pbc_r_r <= ctrl_r[`DPP_C_CRX] ? compand(fin_r, ctrl_r[`DPP_C_ALAW]) : 8'h00;
                cpc_l_r <= ctrl_r[`DPP_C_CTX] ? compand(a_l_r, ctrl_r[`DPP_C_ALAW]) : 8'h00;
                cpc_r_r <= ctrl_r[`DPP_C_CTX] ? compand(a_r_r, ctrl_r[`DPP_C_ALAW]) : 8'h00;
            end
        end
    end
    assign out_l = out_l_r;
    assign out_r = out_r_r;
    assign out_valid = out_valid_r;
    assign pb_code_l = pbc_l_r;
    assign pb_code_r = pbc_r_r;
    assign cap_code_l = cpc_l_r;
    assign cap_code_r = cpc_r_r;

    // headphone attenuate sequencer, counts in samples
    reg [10:0] zcnt_r;
    reg [7:0] scnt_r;
    reg [5:0] save_r;
    wire auto_en = att_r[8];
    wire man_en = att_r[9];
    wire in_zero = (sp_l == 16'h0000) && (sp_r == 16'h0000);
    wire zrun = zcnt_r == `DPP_ZERO_RUN;
    reg [7:0] up_int;
    always @* begin
        case (att_r[11:10])
            2'h0: up_int = 8'h01;
            2'h1: up_int = 8'h10;
            2'h2: up_int = 8'h20;
            default: up_int = 8'h80;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zcnt_r <= 11'h000;
            scnt_r <= 8'h00;
            save_r <= 6'h00;
            hpa_r <= 6'h00;
            st_r <= ST_IDLE;
        end else if (smp_valid) begin
            if (!in_zero)
                zcnt_r <= 11'h000;
            else if (!zrun)
                zcnt_r <= zcnt_r + 11'h001;
            case (st_r)
                ST_IDLE: begin
                    hpa_r <= att_r[5:0];
                    save_r <= att_r[5:0];
                    scnt_r <= 8'h00;
                    if (man_en || (auto_en && zrun))
                        st_r <= ST_DOWN;
                end
                ST_DOWN: begin
                    if ((man_en == 1'b0) && !(auto_en && in_zero)) begin
                        st_r <= ST_UP;
                        scnt_r <= 8'h00;
                    end else if (scnt_r == `DPP_DOWN_STEP - 8'h01) begin
                        scnt_r <= 8'h00;
                        if (hpa_r < `DPP_ATT_MAX)
                            hpa_r <= hpa_r + 6'h01;
                    end else
                        scnt_r <= scnt_r + 8'h01;
                end
                ST_UP: begin
                    if (man_en || (auto_en && zrun)) begin
                        st_r <= ST_DOWN;
                        scnt_r <= 8'h00;
                    end else if (hpa_r <= save_r)
                        st_r <= ST_IDLE;
                    else if (scnt_r >= up_int - 8'h01) begin
                        scnt_r <= 8'h00;
                        hpa_r <= hpa_r - 6'h01;
                    end else
                        scnt_r <= scnt_r + 8'h01;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign hp_atten = hpa_r;
endmodule
`default_nettype wire

// ===== sim/dpp_top_monitor.sv
// port assertions for the playback path
`timescale 1ns/1ps
`default_nettype none
module dpp_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    input wire logic smp_valid,
    input wire logic out_valid,
    input wire logic [7:0] paddr,
    input wire logic [7:0] pb_code_l,
    input wire logic [7:0] cap_code_l,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [23:0] out_l,
    input wire logic [23:0] out_r,
    input wire logic [1:0] osr_sel,
    input wire logic [5:0] hp_atten
);
    wire [1:0] wd_osr = pwdata[2:1];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_out_latency: assert property (smp_valid |-> ##2 out_valid)
        else $error("no output two cycles after a sample");
    a_valid_cause: assert property (out_valid |-> $past(smp_valid, 2))
        else $error("output without a sample");
    a_out_hold: assert property (!out_valid |-> $stable(out_l) && $stable(out_r))
        else $error("output moved between samples");
    a_code_hold: assert property (!out_valid |-> $stable(pb_code_l) && $stable(cap_code_l))
        else $error("code moved between samples");
    a_osr_set: assert property (psel && penable && pwrite && paddr == 8'h00
        |=> osr_sel == $past(wd_osr))
        else $error("ratio select not taken");
    a_atten_cap: assert property (hp_atten <= 6'h36)
        else $error("attenuation past floor");
    a_atten_step: assert property ($changed(hp_atten)
        |-> hp_atten == $past(hp_atten) + 6'h01 || hp_atten == $past(hp_atten) - 6'h01)
        else $error("attenuation jumped");
    a_err_unmapped: assert property (psel && !penable && paddr[7:5] != 3'h0
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && !penable && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0
        |=> !pslverr)
        else $error("mapped access refused");
endmodule
`default_nettype wire

// ===== sim/dpp_host_src.sv
// sample source standing in for the host serial port
`timescale 1ns/1ps
`default_nettype none
module dpp_host_src (
    input wire logic pclk,
    output logic smp_valid,
    output logic [15:0] sp_l,
    output logic [15:0] sp_r,
    output logic [23:0] adc_l,
    output logic [23:0] adc_r
);
    initial begin
        smp_valid = 1'b0;
        {sp_l, sp_r, adc_l, adc_r} = '0;
    end
    // host sends full 16-bit words even when companding is on
    task automatic send(input int n, input logic [15:0] l, r,
        input logic [23:0] al = 24'h0, input logic [23:0] ar = 24'h0);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            {smp_valid, sp_l, sp_r, adc_l, adc_r} <= {1'b1, l, r, al, ar};
            @(posedge pclk);
            // lines stale outside the pulse, so show garbage
            {smp_valid, sp_l, sp_r, adc_l, adc_r} <= {1'b0, ~l, ~r, ~al, ~ar};
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ===== sim/dpp_top_tb.sv
// self-checking bench for the playback path
`timescale 1ns/1ps
`default_nettype none
module dpp_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, smp_valid, out_valid;
    logic [7:0] paddr, pb_code_l, pb_code_r, cap_code_l, cap_code_r;
    logic [31:0] pwdata, prdata;
    logic [15:0] sp_l, sp_r;
    logic [23:0] adc_l, adc_r, out_l, out_r;
    logic [1:0] osr_sel;
    logic [5:0] hp_atten;
    int error_cnt = 0;
    int check_count = 0;
    dpp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp_valid(smp_valid), .sp_l(sp_l), .sp_r(sp_r), .adc_l(adc_l),
        .adc_r(adc_r), .out_valid(out_valid), .out_l(out_l), .out_r(out_r),
        .osr_sel(osr_sel), .pb_code_l(pb_code_l), .pb_code_r(pb_code_r),
        .cap_code_l(cap_code_l), .cap_code_r(cap_code_r), .hp_atten(hp_atten));
    dpp_host_src src (.pclk(pclk), .smp_valid(smp_valid), .sp_l(sp_l), .sp_r(sp_r),
        .adc_l(adc_l), .adc_r(adc_r));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(nm, x, q);
        chk("pslverr", xe, e);
    endtask
    task automatic t_regs();
        rchk("ctrl", 8'h00, 32'h0, 1'b0);
        rchk("vol", 8'h04, 32'hCECE, 1'b0);
        rchk("mix", 8'h08, 32'h21, 1'b0);
        rchk("drc2", 8'h10, 32'h16F, 1'b0);
        rchk("unmapped", 8'h20, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, i << 1);
            chk("osr_sel", i, osr_sel);
        end
        wr(8'h00, 32'h0);
        $display("regs test done");
    endtask
    task automatic t_path();
        src.send(1, 16'h1234, 16'hC000);
        chk("out_l", 24'h123400, out_l);
        chk("out_r", 24'hC00000, out_r);
        wr(8'h00, 32'h1);
        src.send(1, 16'h1234, 16'hC000);
        chk("inv_l", 24'hEDCC00, out_l);
        wr(8'h00, 32'h10);
        src.send(1, 16'h1234, 16'hC000);
        chk("mute_l", 24'h0, out_l);
        chk("live_r", 24'hC00000, out_r);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h14);
        src.send(1, 16'h1234, 16'hC000, 24'h0ABCDE);
        chk("mix_l", 24'h0ABCDE, out_l);
        chk("mix_r", 24'h123400, out_r);
        wr(8'h08, 32'h21);
        $display("path test done");
    endtask
    task automatic t_drc();
        // flat limiter with a -12dB knee pins a full-scale tone near -12dB
        wr(8'h10, 32'h18168);
        wr(8'h0C, 32'h10000);
        src.send(4, 16'h7FFF, 16'h0);
        chk("drc_l", 1, out_l > 24'h1C0000 && out_l < 24'h290000);
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h16F);
        $display("compressor test done");
    endtask
    task automatic t_soft();
        wr(8'h00, 32'h8);
        src.send(4, 16'h1234, 16'h1234);
        chk("ramp_dn", 1, out_l != 24'h0 && out_l != 24'h123400);
        src.send(210, 16'h1234, 16'h1234);
        chk("silent", 24'h0, out_l);
        wr(8'h00, 32'h0);
        src.send(4, 16'h1234, 16'h1234);
        chk("ramp_up", 1, out_l != 24'h0 && out_l != 24'h123400);
        src.send(210, 16'h1234, 16'h1234);
        chk("back", 24'h123400, out_l);
        $display("soft mute test done");
    endtask
    task automatic t_compand();
        logic [7:0] hi, zr;
        for (int law = 0; law < 2; law++) begin
            hi = law ? 8'hAA : 8'h80;
            zr = law ? 8'hD5 : 8'hFF;
            wr(8'h00, 32'h180 | law << 9);
            src.send(2, 16'h7FFF, 16'h0, 24'h7FFFFF);
            chk("pb_l", hi, pb_code_l);
            chk("pb_r", zr, pb_code_r);
            chk("cap_l", hi, cap_code_l);
            chk("cap_r", zr, cap_code_r);
        end
        wr(8'h00, 32'h0);
        src.send(1, 16'h7FFF, 16'h0);
        chk("pb_off", 8'h0, pb_code_l);
        $display("compand test done");
    endtask
    task automatic t_atten();
        wr(8'h18, 32'h100);
        src.send(1000, 16'h0, 16'h0);
        src.send(1, 16'h0001, 16'h0);
        src.send(1000, 16'h0, 16'h0);
        chk("no_atten", 6'h0, hp_atten);
        src.send(400, 16'h0, 16'h0);
        chk("atten_on", 1, hp_atten >= 6'h1 && hp_atten <= 6'h3);
        src.send(60, 16'h0100, 16'h0);
        chk("restored", 6'h0, hp_atten);
        wr(8'h18, 32'h200);
        src.send(7100, 16'h0, 16'h0);
        chk("floor", 6'h36, hp_atten);
        rchk("stat", 8'h1C, 32'h019D9CB6, 1'b0);
        wr(8'h18, 32'h0);
        src.send(60, 16'h0, 16'h0);
        chk("undone", 6'h0, hp_atten);
        $display("attenuate test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_path();
        t_drc();
        t_soft();
        t_compand();
        t_atten();
        complete_run();
    end
    // whole run needs about 30k cycles
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        $display("unexpected watchdog: expected finish seen timeout");
        complete_run();
    end
endmodule
bind dpp_top dpp_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .smp_valid(smp_valid),
    .out_valid(out_valid), .paddr(paddr), .pb_code_l(pb_code_l), .cap_code_l(cap_code_l),
    .pwdata(pwdata), .prdata(prdata), .out_l(out_l), .out_r(out_r), .osr_sel(osr_sel),
    .hp_atten(hp_atten));
`default_nettype wire
